// ### pkg/crp_pkg.sv
package crp_pkg;
  // width of the gated address, bank and command strobe group
  localparam int CRP_DATA_W     = 22;
  // clock-enable and termination lines per group
  localparam int CRP_CTL_W      = 2;
  // chip-select inputs that take part in gating and parity
  localparam int CRP_NUM_SEL    = 4;
  // cycles the fault line is held low after a mismatch
  localparam int CRP_FAULT_HOLD = 2;
  localparam int CRP_HOLD_W     = 2;
  // parity record buffer depth
  localparam int CRP_FIFO_DEPTH = 4;
  // parity record width: one data parity bit per selected cycle
  localparam int CRP_REC_W      = 1;
  // reset values
  localparam logic CRP_LOW_RST   = 1'b0;
  localparam logic [CRP_HOLD_W-1:0] CRP_HOLD_RST = 2'h0;
endpackage

// ### rtl/crp_fifo.sv
`timescale 1ns/1ps
module crp_fifo #(
  parameter int W     = crp_pkg::CRP_REC_W,
  parameter int DEPTH = crp_pkg::CRP_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import crp_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  generate
    if (W < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("crp_fifo: W must be >= 1 and DEPTH a power of two >= 2");
    end
  endgenerate

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] wr_nxt;
  logic [PW-1:0] rd_r;
  logic [PW-1:0] rd_nxt;
  logic [PW:0]   cnt_r;
  logic [PW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    in_ready  = (cnt_r != DEPTH_C);
    out_valid = (cnt_r != '0);
    out_data  = mem_r[rd_r];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wr_nxt    = push ? wr_r + 1'b1 : wr_r;
    rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt   = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // storage carries no reset: it is never read while empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ### rtl/crp_register.sv
`timescale 1ns/1ps
module crp_register #(
  parameter int DATA_W = crp_pkg::CRP_DATA_W,
  parameter int CTL_W  = crp_pkg::CRP_CTL_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [DATA_W-1:0] cmd_addr_in,
  input  wire logic              rank_select0_n,
  input  wire logic              rank_select1_n,
  input  wire logic              rank_select2_n,
  input  wire logic              rank_select3_n,
  input  wire logic              select_gating_strap,
  input  wire logic [CTL_W-1:0]  clock_enable_in,
  input  wire logic [CTL_W-1:0]  termination_in,
  input  wire logic              late_parity_bit,
  output logic [DATA_W-1:0]      cmd_addr_out,
  output logic                   rank_select0_out,
  output logic                   rank_select1_out,
  output logic [CTL_W-1:0]       clock_enable_out,
  output logic [CTL_W-1:0]       termination_out,
  output logic                   parity_fault_n_out,
  output logic                   parity_fault_n_oe
);
  import crp_pkg::*;

  generate
    if (DATA_W < 1 || CTL_W < 1) begin : g_bad
      $error("crp_register: DATA_W and CTL_W must be >= 1");
    end
  endgenerate

  localparam logic [CRP_HOLD_W-1:0] HOLD_C = CRP_HOLD_W'(CRP_FAULT_HOLD);

  // true when at least one select line is active (low)
  function automatic logic any_selected(input logic [CRP_NUM_SEL-1:0] sel_n);
    any_selected = ~(&sel_n);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // input capture and re-drive

  logic [CRP_NUM_SEL-1:0] sel_n;
  logic                   sel_any;
  logic                   rx_en_r;
  logic                   rx_en_nxt;
  logic [DATA_W-1:0]      data_r;
  logic [DATA_W-1:0]      data_nxt;
  logic                   cs0_r;
  logic                   cs0_nxt;
  logic                   cs1_r;
  logic                   cs1_nxt;
  logic [CTL_W-1:0]       cke_r;
  logic [CTL_W-1:0]       cke_nxt;
  logic [CTL_W-1:0]       odt_r;
  logic [CTL_W-1:0]       odt_nxt;

  always_comb begin
    sel_n     = {rank_select3_n, rank_select2_n, rank_select1_n, rank_select0_n};
    sel_any   = any_selected(sel_n);
    // receivers come up one edge after release, so that first edge loads nothing
    rx_en_nxt = 1'b1;
    data_nxt  = data_r;
    cs0_nxt   = cs0_r;
    cs1_nxt   = cs1_r;
    cke_nxt   = cke_r;
    odt_nxt   = odt_r;
    if (rx_en_r) begin
      if (!select_gating_strap || sel_any) begin
        data_nxt = cmd_addr_in;
      end
      cs0_nxt = rank_select0_n;
      cs1_nxt = rank_select1_n;
      cke_nxt = clock_enable_in;
      odt_nxt = termination_in;
    end
  end

  // async clear only, constants only; reset wins over gating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_en_r <= CRP_LOW_RST;
      data_r  <= '0;
      cs0_r   <= CRP_LOW_RST;
      cs1_r   <= CRP_LOW_RST;
      cke_r   <= '0;
      odt_r   <= '0;
    end else begin
      rx_en_r <= rx_en_nxt;
      data_r  <= data_nxt;
      cs0_r   <= cs0_nxt;
      cs1_r   <= cs1_nxt;
      cke_r   <= cke_nxt;
      odt_r   <= odt_nxt;
    end
  end

  always_comb begin
    cmd_addr_out     = data_r;
    rank_select0_out = cs0_r;
    rank_select1_out = cs1_r;
    clock_enable_out = cke_r;
    termination_out  = odt_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // parity records: one per selected cycle, drained when its late bit arrives

  logic                 rec_push;
  logic                 rec_ready;
  logic [CRP_REC_W-1:0] rec_in;
  logic                 rec_valid;
  logic [CRP_REC_W-1:0] rec_out;

  always_comb begin
    // strap plays no part here; records only when a select is low
    rec_push = rx_en_r & sel_any & rec_ready;
    rec_in   = ^cmd_addr_in;
  end

  crp_fifo #(
    .W     (CRP_REC_W),
    .DEPTH (CRP_FIFO_DEPTH)
  ) u_rec_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rec_push),
    .in_ready  (rec_ready),
    .in_data   (rec_in),
    .out_valid (rec_valid),
    .out_ready (rx_en_r),
    .out_data  (rec_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // check, extra delay stage and two-cycle hold

  logic                  chk_r;
  logic                  chk_nxt;
  logic [CRP_HOLD_W-1:0] hold_r;
  logic [CRP_HOLD_W-1:0] hold_nxt;
  logic                  oe_r;
  logic                  oe_nxt;

  always_comb begin
    // late bit pairs with the record pushed one edge earlier
    chk_nxt  = rx_en_r & rec_valid & ~(rec_out[0] ^ late_parity_bit);
    oe_nxt   = chk_r | (hold_r > 2'h1);
    hold_nxt = hold_r;
    if (chk_r) begin
      hold_nxt = HOLD_C;
    end else if (hold_r != CRP_HOLD_RST) begin
      hold_nxt = hold_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_r  <= CRP_LOW_RST;
      hold_r <= CRP_HOLD_RST;
      oe_r   <= CRP_LOW_RST;
    end else begin
      chk_r  <= chk_nxt;
      hold_r <= hold_nxt;
      oe_r   <= oe_nxt;
    end
  end

  // open drain: only ever pulls low, the line floats high otherwise
  always_comb begin
    parity_fault_n_out = CRP_LOW_RST;
    parity_fault_n_oe  = oe_r;
  end
endmodule

// ### verification/crp_register_monitor.sv
`timescale 1ns/1ps
module crp_register_monitor #(
  parameter int DATA_W = 22,
  parameter int CTL_W  = 2
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [DATA_W-1:0] cmd_addr_in,
  input wire logic              rank_select0_n,
  input wire logic              rank_select1_n,
  input wire logic              rank_select2_n,
  input wire logic              rank_select3_n,
  input wire logic              select_gating_strap,
  input wire logic [CTL_W-1:0]  clock_enable_in,
  input wire logic [CTL_W-1:0]  termination_in,
  input wire logic              late_parity_bit,
  input wire logic [DATA_W-1:0] cmd_addr_out,
  input wire logic              rank_select0_out,
  input wire logic              rank_select1_out,
  input wire logic [CTL_W-1:0]  clock_enable_out,
  input wire logic [CTL_W-1:0]  termination_out,
  input wire logic              parity_fault_n_out,
  input wire logic              parity_fault_n_oe
);
  logic live_r, sel_r, px_r, any_sel, mm;
  // receivers count as live from the second edge after release
  assign any_sel = !(rank_select0_n & rank_select1_n & rank_select2_n & rank_select3_n);
  assign mm      = sel_r && !(px_r ^ late_parity_bit);
  always_ff @(posedge clk) begin
    live_r <= rst_n;
    sel_r  <= rst_n && live_r && any_sel;
    px_r   <= ^cmd_addr_in;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst;
    $rose(rst_n) |-> cmd_addr_out == '0 && !parity_fault_n_oe && clock_enable_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_first;
    !live_r |=> cmd_addr_out == '0 && termination_out == '0 && !rank_select0_out;
  endproperty
  a_first: assert property (p_first) else $error("output moved at release");
  property p_gate;
    live_r && select_gating_strap && !any_sel |=> $stable(cmd_addr_out);
  endproperty
  a_gate: assert property (p_gate) else $error("gated data changed");
  property p_load;
    live_r && (!select_gating_strap || any_sel) |=> cmd_addr_out == $past(cmd_addr_in);
  endproperty
  a_load: assert property (p_load) else $error("data not loaded");
  property p_ctl;
    live_r |=> {rank_select0_out, rank_select1_out, clock_enable_out, termination_out}
      == $past({rank_select0_n, rank_select1_n, clock_enable_in, termination_in});
  endproperty
  a_ctl: assert property (p_ctl) else $error("control lines not re-driven");
  property p_fault;
    parity_fault_n_oe == ($past(mm, 2) || $past(mm, 3));
  endproperty
  a_fault: assert property (p_fault) else $error("fault timing wrong");
  property p_hold;
    $rose(parity_fault_n_oe) |-> parity_fault_n_oe [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("fault hold too short");
  property p_od;
    parity_fault_n_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("fault line drives high");
  c_fault: cover property ($rose(parity_fault_n_oe));
  c_gate: cover property (live_r && select_gating_strap && !any_sel);
  c_free: cover property (live_r && !select_gating_strap);
endmodule
bind crp_register crp_register_monitor #(.DATA_W(DATA_W), .CTL_W(CTL_W)) crp_register_monitor_i (
  .clk(clk), .rst_n(rst_n), .cmd_addr_in(cmd_addr_in), .rank_select0_n(rank_select0_n),
  .rank_select1_n(rank_select1_n), .rank_select2_n(rank_select2_n),
  .rank_select3_n(rank_select3_n), .select_gating_strap(select_gating_strap),
  .clock_enable_in(clock_enable_in), .termination_in(termination_in),
  .late_parity_bit(late_parity_bit), .cmd_addr_out(cmd_addr_out),
  .rank_select0_out(rank_select0_out), .rank_select1_out(rank_select1_out),
  .clock_enable_out(clock_enable_out), .termination_out(termination_out),
  .parity_fault_n_out(parity_fault_n_out), .parity_fault_n_oe(parity_fault_n_oe));

// ### verification/crp_ctrl_model.sv
`timescale 1ns/1ps
// req: strap, corrupt, selects 3..0, termination, clock enable, data
module crp_ctrl_model (
  input  wire logic        clk,
  input  wire logic [31:0] req,
  output logic      [30:0] pins = 31'h7c000000,
  output logic             par  = 1'b0
);
  logic bad_r = 1'b0;
  always @(posedge clk) begin
    pins  <= {req[31], req[29:0]};
    bad_r <= req[30];
    par   <= ~(^pins[21:0]) ^ bad_r;
  end
endmodule

// ### verification/crp_register_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t value differs", $time); end end
module crp_register_tb;
  import crp_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] req   = 32'hbc000000;
  logic [30:0] pins;
  logic [21:0] q;
  logic [21:0] eq    = 22'h0;
  logic [31:0] r;
  logic [3:0]  ctl;
  logic [1:0]  rs;
  logic        par, oe, od;
  int          fail_count = 0;
  int          num_checks = 0;
  int          i, n;
  // strap, corrupt, selects, termination and clock enable, data
  logic [31:0] rows [8] = '{32'h3d6aaaaa, 32'hfe955555, 32'hb8d55555, 32'hf43fffff,
                            32'hefc00001, 32'h9c000000, 32'h5e523456, 32'h7d800003};
  wire         fault_n = oe ? od : 1'b1;
  initial forever #20 clk = ~clk;
  crp_ctrl_model crp_ctrl_model_i (.clk(clk), .req(req), .pins(pins), .par(par));
  crp_register crp_register_i (.clk(clk), .rst_n(rst_n), .cmd_addr_in(pins[21:0]),
    .rank_select0_n(pins[26]), .rank_select1_n(pins[27]), .rank_select2_n(pins[28]),
    .rank_select3_n(pins[29]), .select_gating_strap(pins[30]),
    .clock_enable_in(pins[23:22]), .termination_in(pins[25:24]), .late_parity_bit(par),
    .cmd_addr_out(q), .rank_select0_out(rs[0]), .rank_select1_out(rs[1]),
    .clock_enable_out(ctl[1:0]), .termination_out(ctl[3:2]), .parity_fault_n_out(od),
    .parity_fault_n_oe(oe));
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      r = rows[i];
      req <= r;
      @(posedge clk);
      req <= {6'h2f, r[25:0]};
      @(posedge clk);
      #1;
      if (!(r[31] && r[29:26] == 4'hf)) eq = r[21:0];
      `CHK(q, eq)
      `CHK(rs, r[27:26])
      `CHK(ctl, r[25:22])
      repeat (2) @(posedge clk);
      #1;
      `CHK(fault_n, !(r[30] && r[29:26] != 4'hf))
      repeat (3) @(posedge clk);
      $display("row %0d done", i);
    end
    // two corrupt commands back to back stretch the hold by one cycle
    req <= 32'hc0000000;
    repeat (2) @(posedge clk);
    req <= 32'hbc000000;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 n += oe;
    end
    `CHK(n, 3)
    $display("back to back done");
    req <= 32'hc0000000;
    @(posedge clk);
    req <= 32'hbc000000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b0;
    req   <= 'x;
    #1;
    `CHK(fault_n, 1'b1)
    `CHK({q, rs, ctl}, 28'h0)
    repeat (2) @(posedge clk);
    #1 `CHK(q, 22'h0)
    req <= 32'hbc000000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK({q, ctl}, 26'h0)
    $display("reset tests done");
    end_of_test();
  end
endmodule
